// *** pid_params.svh ***
// Functional notes
// - Error equals setpoint minus process value, zero when they match.
// - Nonzero gain: integral coefficient is gain times sample period over integral period.
// - Nonzero gain: derivative coefficient is gain times rate period over sample period.
// - Derivative term uses process value change, not error change.
// - Position output combines proportional, bias (integral plus initial output) and derivative: P - D + bias direct, -P + D + bias reverse.
// - Direct acting with bias adjust: bias scaled by new over old setpoint, clamped 0..1.
// - Reverse acting with bias adjust: bias scaled by old over new setpoint, clamped.
// - Setpoint step scaling happens only when bias adjust is enabled.
// - Integral period 9999 or 0000 removes integral action.
// - Rate period zero removes derivative action.
// - Gain zero removes proportional action, integral and derivative still act.
// - Gain zero: integral coefficient is sample period over integral period.
// - Gain zero: derivative coefficient is rate period over sample period.
// - Bias starts at initial output and each sample adds integral coefficient times error, or subtracts it when reverse acting.
// - Output is clamped to the nearer bound of 0..1.
`ifndef PID_PARAMS_SVH
`define PID_PARAMS_SVH
`define PID_FRAC 16
`define PID_ONE 32'h0001_0000
`define PID_ONE_W 34'h0_0001_0000
`define PID_ZERO_W 34'h0_0000_0000
`define PID_TI_OFF_A 32'h0000_270F
`define PID_TI_OFF_B 32'h0000_0000
`define PID_REG_CTRL 4'h0
`define PID_REG_STATUS 4'h1
`define PID_REG_SETPOINT 4'h2
`define PID_REG_PROCESS 4'h3
`define PID_REG_GAIN 4'h4
`define PID_REG_SAMPLE 4'h5
`define PID_REG_INTEGRAL 4'h6
`define PID_REG_RATE 4'h7
`define PID_REG_INITIAL 4'h8
`define PID_REG_BIAS 4'h9
`define PID_REG_OUTPUT 4'hA
`define PID_CTRL_ENABLE 0
`define PID_CTRL_REVERSE 1
`define PID_CTRL_BIASADJ 2
`define PID_CTRL_REARM 3
`define PID_CTRL_RESET 3'h0
`define PID_WORD_RESET 32'h0000_0000
`endif

// *** pid_pkg.sv ***
package pid_pkg;
    typedef logic signed [31:0] pid_word_t;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_KI,
        ST_KR,
        ST_SCALE,
        ST_ACC,
        ST_OUT
    } pid_state_t;
endpackage

// *** pid_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
// Restoring unsigned divider, one quotient bit per clock
module pid_divider #(
    parameter int DW = 64,
    parameter int VW = 32
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [DW-1:0] dividend,
    input wire logic [VW-1:0] divisor,
    output logic done,
    output logic [DW-1:0] quotient
);
    localparam int CW = $clog2(DW + 1);
    logic [VW:0] remQ, remD;
    logic [DW-1:0] quoQ, quoD;
    logic [VW-1:0] dvsQ, dvsD;
    logic [CW-1:0] cntQ, cntD;
    logic doneQ, doneD;
    logic [VW:0] shifted;

    // Next state; a zero divisor yields all ones, callers guard against it
    always_comb begin
        remD = remQ;
        quoD = quoQ;
        dvsD = dvsQ;
        cntD = cntQ;
        doneD = 1'b0;
        shifted = {remQ[VW-1:0], quoQ[DW-1]};
        if (start) begin
            remD = '0;
            quoD = dividend;
            dvsD = divisor;
            cntD = CW'(DW);
        end else if (cntQ != '0) begin
            if (shifted >= {1'b0, dvsQ}) begin
                remD = shifted - {1'b0, dvsQ};
                quoD = {quoQ[DW-2:0], 1'b1};
            end else begin
                remD = shifted;
                quoD = {quoQ[DW-2:0], 1'b0};
            end
            cntD = cntQ - CW'(1);
            doneD = (cntQ == CW'(1));
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            remQ <= '0;
            quoQ <= '0;
            dvsQ <= '0;
            cntQ <= '0;
            doneQ <= 1'b0;
        end else begin
            remQ <= remD;
            quoQ <= quoD;
            dvsQ <= dvsD;
            cntQ <= cntD;
            doneQ <= doneD;
        end
    end

    assign done = doneQ;
    assign quotient = quoQ;
endmodule
`default_nettype wire

// *** pid_update.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pid_params.svh"
module pid_update (
    input wire logic clk,
    input wire logic reset,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic sampleStrobe,
    output logic [31:0] controlOutput,
    output logic updateDone
);
    // Q16.16 signed product, truncated back to a word
    function automatic pid_pkg::pid_word_t mulq(input pid_pkg::pid_word_t a,
                                               input pid_pkg::pid_word_t b);
        logic signed [63:0] p;
        p = a * b;
        mulq = p[`PID_FRAC+31:`PID_FRAC];
    endfunction

    // Limit a widened value to the normalized 0..1 range
    function automatic logic [31:0] clamp01(input logic signed [33:0] v);
        if (v < $signed(`PID_ZERO_W)) begin
            clamp01 = 32'h0000_0000;
        end else if (v > $signed(`PID_ONE_W)) begin
            clamp01 = `PID_ONE;
        end else begin
            clamp01 = v[31:0];
        end
    endfunction

    // Byte-lane merge for Avalon writes
    function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            bmerge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    logic respQ, respD;
    logic [31:0] rdataQ, rdataD;
    logic [3:0] regIdx;
    logic wrEn;
    logic [2:0] ctrlQ, ctrlD;
    pid_pkg::pid_word_t spQ, spD, pvQ, pvD, gainQ, gainD, tsQ, tsD;
    pid_pkg::pid_word_t tiQ, tiD, tdQ, tdD, initQ, initD;
    pid_pkg::pid_state_t stQ, stD;
    pid_pkg::pid_word_t errQ, errD, kiQ, kiD, krQ, krD, biasQ, biasD;
    pid_pkg::pid_word_t spCurQ, spCurD, pvCurQ, pvCurD, spPrevQ, spPrevD, pvPrevQ, pvPrevD;
    logic [31:0] outQ, outD;
    logic firstQ, firstD, doneQ, doneD;
    logic divStart, divDone;
    logic [63:0] divDividend, divQuot;
    logic [31:0] divDivisor;
    logic tiOff, rateOff, scaleWanted;
    pid_pkg::pid_word_t base, pTerm, dTerm, iTerm;
    logic [31:0] biasClamped;
    logic signed [33:0] mSum;

    // Avalon slave: one wait state, request taken at the second edge
    assign regIdx = address[5:2];
    assign wrEn = write && respQ;
    assign waitrequest = (read || write) && !respQ;

    always_comb begin
        respD = (read || write) && !respQ;
        rdataD = rdataQ;
        if (read && !respQ) begin
            case (regIdx)
                `PID_REG_CTRL: rdataD = {29'h0, ctrlQ};
                `PID_REG_STATUS: rdataD = {30'h0, firstQ, stQ != pid_pkg::ST_IDLE};
                `PID_REG_SETPOINT: rdataD = spQ;
                `PID_REG_PROCESS: rdataD = pvQ;
                `PID_REG_GAIN: rdataD = gainQ;
                `PID_REG_SAMPLE: rdataD = tsQ;
                `PID_REG_INTEGRAL: rdataD = tiQ;
                `PID_REG_RATE: rdataD = tdQ;
                `PID_REG_INITIAL: rdataD = initQ;
                `PID_REG_BIAS: rdataD = biasQ;
                `PID_REG_OUTPUT: rdataD = outQ;
                default: rdataD = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            respQ <= 1'b0;
            rdataQ <= `PID_WORD_RESET;
        end else begin
            respQ <= respD;
            rdataQ <= rdataD;
        end
    end

    assign readdata = rdataQ;

    // Parameter registers written by control software
    always_comb begin
        ctrlD = ctrlQ;
        spD = spQ;
        pvD = pvQ;
        gainD = gainQ;
        tsD = tsQ;
        tiD = tiQ;
        tdD = tdQ;
        initD = initQ;
        if (wrEn) begin
            case (regIdx)
                `PID_REG_CTRL: ctrlD = byteenable[0] ? writedata[2:0] : ctrlQ;
                `PID_REG_SETPOINT: spD = bmerge(spQ, writedata, byteenable);
                `PID_REG_PROCESS: pvD = bmerge(pvQ, writedata, byteenable);
                `PID_REG_GAIN: gainD = bmerge(gainQ, writedata, byteenable);
                `PID_REG_SAMPLE: tsD = bmerge(tsQ, writedata, byteenable);
                `PID_REG_INTEGRAL: tiD = bmerge(tiQ, writedata, byteenable);
                `PID_REG_RATE: tdD = bmerge(tdQ, writedata, byteenable);
                `PID_REG_INITIAL: initD = bmerge(initQ, writedata, byteenable);
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrlQ <= `PID_CTRL_RESET;
            spQ <= `PID_WORD_RESET;
            pvQ <= `PID_WORD_RESET;
            gainQ <= `PID_WORD_RESET;
            tsQ <= `PID_WORD_RESET;
            tiQ <= `PID_WORD_RESET;
            tdQ <= `PID_WORD_RESET;
            initQ <= `PID_WORD_RESET;
        end else begin
            ctrlQ <= ctrlD;
            spQ <= spD;
            pvQ <= pvD;
            gainQ <= gainD;
            tsQ <= tsD;
            tiQ <= tiD;
            tdQ <= tdD;
            initQ <= initD;
        end
    end

    // Shared divider: coefficient ratios and setpoint-step scaling
    pid_divider #(.DW(64), .VW(32)) uDiv (
        .clk(clk),
        .reset(reset),
        .start(divStart),
        .dividend(divDividend),
        .divisor(divDivisor),
        .done(divDone),
        .quotient(divQuot)
    );

    assign tiOff = (tiQ == `PID_TI_OFF_A) || (tiQ == `PID_TI_OFF_B);
    assign rateOff = (tdQ == `PID_WORD_RESET) || (tsQ == `PID_WORD_RESET);
    assign base = divQuot[31:0];
    assign biasClamped = clamp01({{2{biasQ[31]}}, biasQ});
    // Step scaling needs a real step and two positive setpoints to divide by
    assign scaleWanted = ctrlQ[`PID_CTRL_BIASADJ] && (spCurQ != spPrevQ)
        && (spCurQ > 0) && (spPrevQ > 0);
    assign pTerm = mulq(gainQ, errQ);
    assign dTerm = mulq(krQ, pvCurQ - pvPrevQ);
    assign iTerm = mulq(kiQ, errQ);

    // Position form sum, wide enough that it cannot wrap before the clamp
    assign mSum = ctrlQ[`PID_CTRL_REVERSE]
        ? -{{2{pTerm[31]}}, pTerm} + {{2{dTerm[31]}}, dTerm} + {{2{biasQ[31]}}, biasQ}
        : {{2{pTerm[31]}}, pTerm} - {{2{dTerm[31]}}, dTerm} + {{2{biasQ[31]}}, biasQ};

    // Update sequencer; strobes while busy are ignored
    always_comb begin
        stD = stQ;
        errD = errQ;
        kiD = kiQ;
        krD = krQ;
        biasD = biasQ;
        spCurD = spCurQ;
        pvCurD = pvCurQ;
        spPrevD = spPrevQ;
        pvPrevD = pvPrevQ;
        outD = outQ;
        firstD = firstQ;
        doneD = 1'b0;
        divStart = 1'b0;
        divDividend = {32'h0000_0000, tsQ} << `PID_FRAC;
        divDivisor = tiQ;
        // A direct bias write is kept unless the sequencer loads bias in the same cycle (first strobe, ST_SCALE, ST_ACC)
        if (wrEn && regIdx == `PID_REG_BIAS) begin
            biasD = bmerge(biasQ, writedata, byteenable);
        end
        case (stQ)
            pid_pkg::ST_IDLE: begin
                if (sampleStrobe && ctrlQ[`PID_CTRL_ENABLE]) begin
                    spCurD = spQ;
                    pvCurD = pvQ;
                    errD = spQ - pvQ;
                    if (firstQ) begin
                        biasD = initQ;
                        spPrevD = spQ;
                        pvPrevD = pvQ;
                    end
                    divStart = 1'b1;
                    stD = pid_pkg::ST_KI;
                end
            end
            pid_pkg::ST_KI: begin
                if (divDone) begin
                    if (tiOff) begin
                        kiD = 32'h0000_0000;
                    end else if (gainQ != 0) begin
                        kiD = mulq(gainQ, base);
                    end else begin
                        kiD = base;
                    end
                    divStart = 1'b1;
                    divDividend = {32'h0000_0000, tdQ} << `PID_FRAC;
                    divDivisor = tsQ;
                    stD = pid_pkg::ST_KR;
                end
            end
            pid_pkg::ST_KR: begin
                divDividend = {32'h0000_0000, biasClamped}
                    * (ctrlQ[`PID_CTRL_REVERSE] ? spPrevQ : spCurQ);
                divDivisor = ctrlQ[`PID_CTRL_REVERSE] ? spCurQ : spPrevQ;
                if (divDone) begin
                    if (rateOff) begin
                        krD = 32'h0000_0000;
                    end else if (gainQ != 0) begin
                        krD = mulq(gainQ, base);
                    end else begin
                        krD = base;
                    end
                    divStart = scaleWanted;
                    stD = scaleWanted ? pid_pkg::ST_SCALE : pid_pkg::ST_ACC;
                end
            end
            pid_pkg::ST_SCALE: begin
                if (divDone) begin
                    // Quotient is never negative, so only the top needs limiting
                    biasD = (divQuot > 64'(`PID_ONE)) ? `PID_ONE : base;
                    stD = pid_pkg::ST_ACC;
                end
            end
            pid_pkg::ST_ACC: begin
                biasD = ctrlQ[`PID_CTRL_REVERSE] ? biasQ - iTerm : biasQ + iTerm;
                spPrevD = spCurQ;
                stD = pid_pkg::ST_OUT;
            end
            pid_pkg::ST_OUT: begin
                outD = clamp01(mSum);
                pvPrevD = pvCurQ;
                firstD = 1'b0;
                doneD = 1'b1;
                stD = pid_pkg::ST_IDLE;
            end
            default: stD = pid_pkg::ST_IDLE;
        endcase
        if (wrEn && regIdx == `PID_REG_CTRL && byteenable[0] // Rearm wins over the clear
            && writedata[`PID_CTRL_REARM]) begin
            firstD = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            stQ <= pid_pkg::ST_IDLE;
            errQ <= `PID_WORD_RESET;
            kiQ <= `PID_WORD_RESET;
            krQ <= `PID_WORD_RESET;
            biasQ <= `PID_WORD_RESET;
            spCurQ <= `PID_WORD_RESET;
            pvCurQ <= `PID_WORD_RESET;
            spPrevQ <= `PID_WORD_RESET;
            pvPrevQ <= `PID_WORD_RESET;
            outQ <= `PID_WORD_RESET;
            firstQ <= 1'b1;
            doneQ <= 1'b0;
        end else begin
            stQ <= stD;
            errQ <= errD;
            kiQ <= kiD;
            krQ <= krD;
            biasQ <= biasD;
            spCurQ <= spCurD;
            pvCurQ <= pvCurD;
            spPrevQ <= spPrevD;
            pvPrevQ <= pvPrevD;
            outQ <= outD;
            firstQ <= firstD;
            doneQ <= doneD;
        end
    end

    assign controlOutput = outQ;
    assign updateDone = doneQ;

    // Checks on the update sequence and the bus wait state
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence seqStart;
        stQ == pid_pkg::ST_IDLE && sampleStrobe && ctrlQ[`PID_CTRL_ENABLE];
    endsequence
    sequence seqFinish;
        updateDone && stQ == pid_pkg::ST_IDLE;
    endsequence

    chk_one_update: assert property (seqStart |=> !updateDone ##[1:300] seqFinish)
        else $error("update did not finish after strobe");
    chk_output_range: assert property (updateDone |-> controlOutput <= `PID_ONE)
        else $error("output above one");
    chk_output_hold: assert property (!updateDone |-> $stable(controlOutput))
        else $error("output changed without done pulse");
    chk_error_value: assert property (seqStart |=> errQ == $past(spQ) - $past(pvQ))
        else $error("error not setpoint minus process value");
    chk_integral_off: assert property (stQ == pid_pkg::ST_KR && tiOff |-> kiQ == 0)
        else $error("integral coefficient nonzero while disabled");
    chk_rate_off: assert property (stQ == pid_pkg::ST_ACC && rateOff |-> krQ == 0)
        else $error("derivative coefficient nonzero while disabled");
    chk_scale_gate: assert property (stQ == pid_pkg::ST_SCALE
        |-> ctrlQ[`PID_CTRL_BIASADJ])
        else $error("bias scaled without bias adjust");
    chk_scaled_bias: assert property (stQ == pid_pkg::ST_SCALE && divDone
        |=> biasQ >= 0 && biasQ <= $signed(`PID_ONE))
        else $error("scaled bias outside zero to one");
    chk_first_bias: assert property (seqStart and firstQ |=> biasQ == $past(initQ))
        else $error("bias not loaded from initial output");
    chk_bus_wait: assert property ((read || write) && !respQ |-> waitrequest ##1 !waitrequest)
        else $error("bus answer not after one wait state");
endmodule
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pid_params.svh"
module tb;
    logic clk;
    logic reset;
    logic [5:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
    logic [31:0] readdata;
    logic waitrequest;
    logic sampleStrobe;
    logic [31:0] controlOutput;
    logic updateDone;
    int mismatches;
    int samplesChecked;
    int cycleCount;
    logic [31:0] rdValue;

    pid_update pid_update_inst (
        .clk(clk),
        .reset(reset),
        .address(address),
        .read(read),
        .write(write),
        .writedata(writedata),
        .byteenable(byteenable),
        .readdata(readdata),
        .waitrequest(waitrequest),
        .sampleStrobe(sampleStrobe),
        .controlOutput(controlOutput),
        .updateDone(updateDone)
    );

    // 10 MHz clock
    always #50 clk = ~clk;

    // Hang guard: a full run needs a few thousand cycles, the ceiling leaves ample margin
    always @(posedge clk) begin
        cycleCount <= cycleCount + 1;
    end

    task automatic tally_and_finish();
        $display("Counts: %0d compared, %0d mismatched", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until the edge that sees waitrequest low
    task automatic busWrite(input logic [3:0] idx, input logic [31:0] data);
        @(posedge clk);
        address <= {idx, 2'b00};
        writedata <= data;
        write <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask

    task automatic busRead(input logic [3:0] idx, output logic [31:0] data);
        @(posedge clk);
        address <= {idx, 2'b00};
        read <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        data = readdata;
        read <= 1'b0;
    endtask

    task automatic readCheck(input logic [3:0] idx, input logic [31:0] exp);
        busRead(idx, rdValue);
        check(rdValue, exp);
    endtask

    // One strobe, then the output is checked in the done cycle
    task automatic sample(input logic [31:0] exp);
        @(posedge clk);
        sampleStrobe <= 1'b1;
        @(posedge clk);
        sampleStrobe <= 1'b0;
        do @(posedge clk); while (updateDone !== 1'b1); // Ends on the done pulse; without one, the hang guard ends the run
        check(controlOutput, exp);
    endtask

    task automatic cfg(input logic [31:0] gain, input logic [31:0] ts, input logic [31:0] ti,
                       input logic [31:0] td, input logic [31:0] init, input logic [31:0] ctrl);
        busWrite(`PID_REG_GAIN, gain);
        busWrite(`PID_REG_SAMPLE, ts);
        busWrite(`PID_REG_INTEGRAL, ti);
        busWrite(`PID_REG_RATE, td);
        busWrite(`PID_REG_INITIAL, init);
        busWrite(`PID_REG_CTRL, ctrl);
    endtask

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        address = 6'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        byteenable = 4'hF;
        sampleStrobe = 1'b0;
        mismatches = 0;
        samplesChecked = 0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        fork
            runTests();
            begin
                wait (cycleCount == 40000);
                mismatches++;
                $display("FAIL at %0t: cycles %h expected below %h", $time, cycleCount, 40000);
            end
        join_any
        tally_and_finish();
    end

    // Scenarios in order; each ends with a one-line report
    task automatic runTests();
        // Reset values, read-only and unmapped places
        for (int i = 0; i < 11; i++) begin
            readCheck(i[3:0], (i == 1) ? 32'h0000_0002 : 32'h0000_0000);
        end
        busWrite(`PID_REG_OUTPUT, 32'hFFFF_FFFF);
        readCheck(`PID_REG_OUTPUT, 32'h0000_0000);
        busWrite(4'hC, 32'hFFFF_FFFF);
        readCheck(4'hC, 32'h0000_0000);
        busWrite(`PID_REG_CTRL, 32'h0000_000F);
        readCheck(`PID_REG_CTRL, 32'h0000_0007);
        $display("Test registers done");

        // Proportional only, integral off by both codes, no rate
        cfg(32'h0000_8000, 32'h0000_0001, `PID_TI_OFF_B, 32'h0, 32'h0000_8000, 32'h0000_0009);
        busWrite(`PID_REG_SETPOINT, 32'h0000_8000);
        busWrite(`PID_REG_PROCESS, 32'h0000_8000);
        sample(32'h0000_8000);
        busWrite(`PID_REG_PROCESS, 32'h0000_4000);
        sample(32'h0000_A000);
        readCheck(`PID_REG_BIAS, 32'h0000_8000);
        busWrite(`PID_REG_INTEGRAL, `PID_TI_OFF_A);
        busWrite(`PID_REG_PROCESS, 32'h0000_0000);
        sample(32'h0000_C000);
        busWrite(`PID_REG_PROCESS, 32'hFFFF_0000);
        sample(32'h0001_0000);
        busWrite(`PID_REG_PROCESS, 32'h0003_0000);
        sample(32'h0000_0000);
        $display("Test proportional done");

        // Integral with gain 2.0, then with gain zero
        cfg(32'h0002_0000, 32'h0000_0001, 32'h0000_0002, 32'h0, 32'h0000_2000, 32'h0000_0009);
        busWrite(`PID_REG_SETPOINT, 32'h0000_4000);
        busWrite(`PID_REG_PROCESS, 32'h0000_3000);
        sample(32'h0000_5000);
        readCheck(`PID_REG_BIAS, 32'h0000_3000);
        busWrite(`PID_REG_GAIN, 32'h0000_0000);
        sample(32'h0000_3800);
        $display("Test integral done");

        // Derivative on process value only, then with gain zero
        cfg(32'h0001_0000, 32'h0000_0002, 32'h0, 32'h0000_0001, 32'h0000_4000, 32'h0000_0009);
        busWrite(`PID_REG_SETPOINT, 32'h0000_8000);
        busWrite(`PID_REG_PROCESS, 32'h0000_8000);
        sample(32'h0000_4000);
        busWrite(`PID_REG_PROCESS, 32'h0000_6000);
        sample(32'h0000_7000);
        busWrite(`PID_REG_SETPOINT, 32'h0000_A000);
        sample(32'h0000_8000);
        busWrite(`PID_REG_GAIN, 32'h0000_0000);
        busWrite(`PID_REG_PROCESS, 32'h0000_4000);
        sample(32'h0000_5000);
        $display("Test derivative done");

        // Bias scaling on setpoint steps, direct then reverse, then disabled
        cfg(32'h0, 32'h0000_0001, 32'h0, 32'h0, 32'h0000_4000, 32'h0000_000D);
        busWrite(`PID_REG_SETPOINT, 32'h0000_8000);
        sample(32'h0000_4000);
        busWrite(`PID_REG_SETPOINT, 32'h0001_0000);
        sample(32'h0000_8000);
        readCheck(`PID_REG_BIAS, 32'h0000_8000);
        busWrite(`PID_REG_CTRL, 32'h0000_0007);
        busWrite(`PID_REG_SETPOINT, 32'h0000_8000);
        sample(32'h0001_0000);
        busWrite(`PID_REG_CTRL, 32'h0000_0001);
        busWrite(`PID_REG_BIAS, 32'h0000_3000);
        busWrite(`PID_REG_SETPOINT, 32'h0000_2000);
        sample(32'h0000_3000);
        $display("Test bias scaling done");
    endtask
endmodule
`default_nettype wire
